// >>> inc/pwm_pkg.sv
// Package for the potentiometer wiper and memory map block.
// Shared by the main module and its page buffer.
package pwm_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int WIPER_W = 7;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_COUNT = 128;
    localparam int MEM_BYTES = 2048;
    localparam int PAGE_OFS_W = 4;
    localparam logic [ADDR_W-1:0] GP_LAST_ADDR = 11'h7fb;
    localparam logic [ADDR_W-1:0] RSVD_A_ADDR = 11'h7fc;
    localparam logic [ADDR_W-1:0] RSVD_B_ADDR = 11'h7fd;
    localparam logic [ADDR_W-1:0] ACCESS_CTRL_ADDR = 11'h7fe;
    localparam logic [ADDR_W-1:0] WIPER_IV_ADDR = 11'h7ff;
    localparam logic [WIPER_W-1:0] WIPER_MID = 7'h40;
    localparam logic [WIPER_W-1:0] WIPER_LOW = 7'h00;
    localparam logic [WIPER_W-1:0] WIPER_HIGH = 7'h7f;
    localparam int VOLATILE_BIT = 7;
    localparam logic [DATA_W-1:0] RSVD_READ = 8'h00;
    localparam int CLK_MHZ = 125;
    localparam int PROG_TYP_MS = 6;
    localparam int PROG_MAX_MS = 12;
    // Longest time is an exact cycle count; 125 cycles per us
    localparam int PROG_MAX_CYCLES = PROG_MAX_MS * 1000 * CLK_MHZ;
    localparam int PROG_TYP_CYCLES = PROG_TYP_MS * 1000 * CLK_MHZ;
    localparam int POWERUP_CYCLES = 16;

    typedef enum {PWM_PRESET, PWM_LOAD, PWM_IDLE, PWM_PROG} pwm_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic stop;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pwm_req_t;
endpackage : pwm_pkg

// >>> rtl/pwm_page_buf.sv
// Page latch holding up to one page of pending non-volatile bytes.
// Assumes the parent clears it after each commit.
`timescale 1ns/1ns
module pwm_page_buf
    import pwm_pkg::*;
#(
    parameter int BYTES = PAGE_BYTES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic load,
    input wire logic [$clog2(BYTES)-1:0] sel,
    input wire logic [DATA_W-1:0] din,
    output logic [BYTES-1:0] pend,
    output logic [BYTES*DATA_W-1:0] data
);
    initial begin
        if (BYTES < 2 || (BYTES & (BYTES - 1)) != 0) begin
            $error("BYTES must be a power of two");
        end
    end

    typedef struct packed {
        logic [BYTES-1:0] pend;
        logic [BYTES*DATA_W-1:0] data;
    } pwm_pb_t;

    pwm_pb_t st_reg;
    pwm_pb_t st_next;

    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next.pend = '0;
        end
        if (load) begin
            st_next.pend[sel] = 1'b1;
            st_next.data[sel*DATA_W +: DATA_W] = din;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pend = st_reg.pend;
    assign data = st_reg.data;
endmodule : pwm_page_buf

// >>> rtl/pwm_wiper_map.sv
// Memory map, wiper register and page write cycle of the potentiometer.
// Assumes an upstream serial slave delivers decoded byte requests on mclk.
//
// Behaviour
// - Seven-bit wiper register sets tap position
// - Zero code selects tap nearest low terminal
// - All ones selects tap nearest high terminal
// - Higher code moves tap toward high terminal
// - Wiper preset to mid-scale at power-up
// - Stored initial value copied into wiper afterwards
// - Storage is 2048 bytes, 128 pages of 16
// - Up to 16 page bytes committed together
// - Addresses decode from zero to 0x7FF
// - Bytes up to 0x7FB are plain storage
// - Top byte holds stored initial wiper value
// - Byte 0x7FE is the access-control register
// - Only top control bit meaningful, others zero
// - Programming cycle starts at STOP after a write to storage or stored top byte
// - Programming cycle ends within 12 ms
// - Volatile selector clears at power-up
// - Top read: wiper if selector set, else stored
// - Top write: wiper only, or wiper and stored
`timescale 1ns/1ns
module pwm_wiper_map
    import pwm_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_TYP_CYCLES,
    parameter int BOOT_CYCLES = POWERUP_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire pwm_req_t req,
    output logic [DATA_W-1:0] rdata,
    output logic rvalid,
    output logic busy,
    output logic [WIPER_W-1:0] digital_pot_wiper_register,
    output logic [PAGE_COUNT-1:0] tap_select_low,
    output logic volatile_only_flag
);
    initial begin
        if (PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYCLES) begin
            $error("PROG_CYCLES out of range");
        end
        if (BOOT_CYCLES < 1 || BOOT_CYCLES > 65535) begin
            $error("BOOT_CYCLES out of range");
        end
    end

    localparam logic [22:0] PROG_LAST = 23'(PROG_CYCLES - 1);
    localparam logic [15:0] BOOT_LAST = 16'(BOOT_CYCLES - 1);

    typedef struct packed {
        pwm_state_t state;
        logic [22:0] cnt;
        logic [WIPER_W-1:0] wiper;
        logic vol_only;
        logic nv_dirty;
        logic [ADDR_W-PAGE_OFS_W-1:0] page;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic busy;
        logic [PAGE_COUNT-1:0] taps;
    } pwm_st_t;

    pwm_st_t st_reg;
    pwm_st_t st_next;

    // Non-volatile array; content survives resetn, as the cells would
    logic [DATA_W-1:0] nv_mem [0:MEM_BYTES-1];
    // Cells start erased so the first load after power-up is a known code
    localparam logic [DATA_W-1:0] NV_ERASED = 8'hff;

    initial begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            nv_mem[i] = NV_ERASED;
        end
    end
    logic [PAGE_BYTES-1:0] pb_pend;
    logic [PAGE_BYTES*DATA_W-1:0] pb_data;
    logic pb_load;
    logic pb_clear;
    logic [ADDR_W-1:0] addr;
    logic idle;

    assign addr = req.addr;
    assign idle = (st_reg.state == PWM_IDLE);
    // Writes to general storage and to the stored top byte are paged
    assign pb_load = idle && req.wr && (addr <= GP_LAST_ADDR ||
        (addr == WIPER_IV_ADDR && !st_reg.vol_only));
    assign pb_clear = (st_reg.state == PWM_PROG) && (st_reg.cnt == PROG_LAST);

    pwm_page_buf #(
        .BYTES(PAGE_BYTES)
    ) u_page (
        .mclk(mclk),
        .resetn(resetn),
        .clear(pb_clear),
        .load(pb_load),
        .sel(addr[PAGE_OFS_W-1:0]),
        .din(addr == WIPER_IV_ADDR ? {1'b0, req.wdata[WIPER_W-1:0]} : req.wdata),
        .pend(pb_pend),
        .data(pb_data)
    );

    // One-hot tap switches: the single set bit sits at the code
    function automatic logic [PAGE_COUNT-1:0] pwm_taps(input logic [WIPER_W-1:0] w);
        logic [PAGE_COUNT-1:0] t;
        t = '0;
        for (int i = 0; i < PAGE_COUNT; i++) begin
            t[i] = (WIPER_W'(i) == w);
        end
        return t;
    endfunction : pwm_taps

    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        unique case (st_reg.state)
            PWM_PRESET: begin
                st_next.wiper = WIPER_MID;
                st_next.cnt = st_reg.cnt + 23'h000001;
                if (st_reg.cnt[15:0] == BOOT_LAST) begin
                    st_next.state = PWM_LOAD;
                end
            end
            PWM_LOAD: begin
                st_next.wiper = nv_mem[WIPER_IV_ADDR][WIPER_W-1:0];
                st_next.state = PWM_IDLE;
                st_next.cnt = '0;
            end
            PWM_IDLE: begin
                if (req.rd) begin
                    st_next.rvalid = 1'b1;
                    if (addr == WIPER_IV_ADDR) begin
                        st_next.rdata = st_reg.vol_only ? {1'b0, st_reg.wiper}
                            : {1'b0, nv_mem[WIPER_IV_ADDR][WIPER_W-1:0]};
                    end else if (addr == ACCESS_CTRL_ADDR) begin
                        st_next.rdata = {st_reg.vol_only, 7'h00};
                    end else if (addr == RSVD_A_ADDR || addr == RSVD_B_ADDR) begin
                        st_next.rdata = RSVD_READ;
                    end else begin
                        st_next.rdata = nv_mem[addr];
                    end
                end
                if (req.wr) begin
                    if (addr == WIPER_IV_ADDR) begin
                        st_next.wiper = req.wdata[WIPER_W-1:0];
                    end
                    if (addr == ACCESS_CTRL_ADDR) begin
                        st_next.vol_only = req.wdata[VOLATILE_BIT];
                    end
                    if (pb_load) begin
                        st_next.nv_dirty = 1'b1;
                        st_next.page = addr[ADDR_W-1:PAGE_OFS_W];
                    end
                end
                if (req.stop && (st_reg.nv_dirty || pb_load)) begin
                    st_next.state = PWM_PROG;
                    st_next.cnt = '0;
                end
            end
            PWM_PROG: begin
                st_next.cnt = st_reg.cnt + 23'h000001;
                if (st_reg.cnt == PROG_LAST) begin
                    st_next.state = PWM_IDLE;
                    st_next.nv_dirty = 1'b0;
                    st_next.cnt = '0;
                end
            end
        endcase
        st_next.taps = pwm_taps(st_next.wiper);
        // Registered so the busy output comes straight from a flip-flop
        st_next.busy = (st_next.state != PWM_IDLE);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg.state <= PWM_PRESET;
            st_reg.cnt <= '0;
            st_reg.wiper <= WIPER_MID;
            st_reg.vol_only <= 1'b0;
            st_reg.nv_dirty <= 1'b0;
            st_reg.page <= '0;
            st_reg.rdata <= '0;
            st_reg.rvalid <= 1'b0;
            st_reg.busy <= 1'b1;
            st_reg.taps <= PAGE_COUNT'(1) << WIPER_MID;
        end else begin
            st_reg <= st_next;
        end
    end

    // Commit the pending page bytes in the cycle the programming time elapses
    always_ff @(posedge mclk) begin
        if (pb_clear) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pb_pend[i]) begin
                    nv_mem[{st_reg.page, PAGE_OFS_W'(i)}] <= pb_data[i*DATA_W +: DATA_W];
                end
            end
        end
    end

    assign rdata = st_reg.rdata;
    assign rvalid = st_reg.rvalid;
    assign busy = st_reg.busy;
    assign digital_pot_wiper_register = st_reg.wiper;
    assign tap_select_low = st_reg.taps;
    assign volatile_only_flag = st_reg.vol_only;

    a_wiper_preset: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.state == PWM_PRESET |-> st_reg.wiper == WIPER_MID)
        else $error("wiper not at mid-scale during preset");
    a_load_initial: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.state == PWM_LOAD |=> st_reg.wiper == $past(nv_mem[WIPER_IV_ADDR][6:0]))
        else $error("initial value not loaded");
    a_tap_onehot: assert property (@(posedge mclk) disable iff (!resetn)
        $onehot(st_reg.taps) && st_reg.taps[st_reg.wiper])
        else $error("tap select does not match wiper");
    a_tap_low: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.wiper == WIPER_LOW |-> st_reg.taps[0])
        else $error("zero code not at low terminal");
    a_tap_high: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.wiper == WIPER_HIGH |-> st_reg.taps[PAGE_COUNT-1])
        else $error("full code not at high terminal");
    a_stop_starts: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.stop && pb_load |=> st_reg.state == PWM_PROG)
        else $error("stop did not start programming");
    a_prog_bound: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.state == PWM_PROG |-> st_reg.cnt <= PROG_LAST)
        else $error("programming overran its time");
    a_top_read: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && addr == WIPER_IV_ADDR && st_reg.vol_only
        |=> rvalid && rdata == {1'b0, $past(st_reg.wiper)})
        else $error("top read wrong in volatile mode");
    a_ctrl_read: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && addr == ACCESS_CTRL_ADDR |=> rdata[6:0] == 7'h00)
        else $error("control low bits not zero");
    a_top_write: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.wr && addr == WIPER_IV_ADDR |=> st_reg.wiper == $past(req.wdata[6:0]))
        else $error("top write did not update wiper");
    a_busy_level: assert property (@(posedge mclk) disable iff (!resetn)
        busy == (st_reg.state != PWM_IDLE))
        else $error("busy does not follow state");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.wr && addr == ACCESS_CTRL_ADDR
        |=> volatile_only_flag == $past(req.wdata[VOLATILE_BIT]))
        else $error("selector not written");
    a_rsvd_read: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && (addr == RSVD_A_ADDR || addr == RSVD_B_ADDR)
        |=> rdata == RSVD_READ)
        else $error("reserved byte read not fixed");
    a_gp_read: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && addr <= GP_LAST_ADDR |=> rdata == $past(nv_mem[addr]))
        else $error("storage read wrong");
    a_top_msb: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && addr == WIPER_IV_ADDR |=> rdata[DATA_W-1] == 1'b0)
        else $error("top byte msb not zero");
    a_stop_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.stop && !st_reg.nv_dirty && !pb_load |=> idle)
        else $error("programming without pending bytes");
    a_prog_hold: assert property (@(posedge mclk) disable iff (!resetn)
        st_reg.state == PWM_PROG && req.wr |=> st_reg.wiper == $past(st_reg.wiper))
        else $error("write taken while programming");
    a_prog_commit: assert property (@(posedge mclk) disable iff (!resetn)
        pb_clear |=> idle && !st_reg.nv_dirty)
        else $error("programming did not end after commit");
    a_vol_nostore: assert property (@(posedge mclk) disable iff (!resetn)
        idle && req.wr && addr == WIPER_IV_ADDR && st_reg.vol_only |-> !pb_load)
        else $error("volatile write reached storage");
    c_boot_load: cover property (@(posedge mclk) disable iff (!resetn)
        st_reg.state == PWM_LOAD);
    c_prog: cover property (@(posedge mclk) disable iff (!resetn) pb_clear);
    c_vol_write: cover property (@(posedge mclk) disable iff (!resetn)
        idle && req.wr && addr == WIPER_IV_ADDR && st_reg.vol_only);
    c_gp_read: cover property (@(posedge mclk) disable iff (!resetn)
        idle && req.rd && addr <= GP_LAST_ADDR);
endmodule : pwm_wiper_map

// >>> verification/pwm_host_model.sv
// Host-side model issuing decoded byte requests toward the wiper map.
// Assumes one caller at a time; every request changes just after a rising edge.
`timescale 1ns/1ns
module pwm_host_model
    import pwm_pkg::*;
(
    input wire logic mclk,
    input wire logic busy,
    output pwm_req_t req
);
    initial req = '0;
    task automatic put(input logic w, input logic r, input logic s,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        req <= '{wr: w, rd: r, stop: s, addr: a, wdata: d};
    endtask : put
    // Waits out power-up and programming instead of polling for acknowledge
    task automatic ready();
        int n;
        n = 0;
        repeat (2) @(posedge mclk);
        #1;
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : ready
    task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (a == RSVD_A_ADDR || a == RSVD_B_ADDR) return;
        put(1'b1, 1'b0, 1'b0, a, (a == ACCESS_CTRL_ADDR) ? (d & 8'h80) : d);
    endtask : write
    task automatic stop();
        put(1'b0, 1'b0, 1'b1, '0, '0);
        put(1'b0, 1'b0, 1'b0, '0, '0);
    endtask : stop
    task automatic read(input logic [ADDR_W-1:0] a);
        put(1'b0, 1'b1, 1'b0, a, '0);
        put(1'b0, 1'b0, 1'b0, '0, '0);
    endtask : read
endmodule : pwm_host_model

// >>> verification/testbench.sv
// Self-checking bench for the wiper map, with a reference model kept in ints.
// Assumes short programming and boot counts set through the design parameters.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import pwm_pkg::*;
    localparam int PROG_C = 20;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    pwm_req_t req;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic busy;
    logic volatile_only_flag;
    logic [WIPER_W-1:0] wiper;
    logic [PAGE_COUNT-1:0] taps;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int nv [MEM_BYTES];
    int pa [$];
    int pd [$];
    int wip = 'h40;
    int flg = 0;
    int p;
    int c;
    always #4 mclk = ~mclk;
    pwm_wiper_map #(.PROG_CYCLES(PROG_C), .BOOT_CYCLES(2)) i_dut (
        .mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
        .busy(busy), .digital_pot_wiper_register(wiper), .tap_select_low(taps),
        .volatile_only_flag(volatile_only_flag));
    pwm_host_model i_host (.mclk(mclk), .busy(busy), .req(req));
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    function automatic int exp_rd(input int a);
        if (a == 'h7fe) return flg << 7;
        if (a == 'h7ff) return flg ? wip : nv[a];
        return nv[a];
    endfunction : exp_rd
    task automatic chk_wiper();
        `CHK(wiper, WIPER_W'(wip))
        `CHK(taps, PAGE_COUNT'(1) << wip)
    endtask : chk_wiper
    task automatic wr(input int a, input int d);
        i_host.write(ADDR_W'(a), DATA_W'(d));
        if (a == 'h7fc || a == 'h7fd) return;
        if (a == 'h7fe) flg = (d >> 7) & 1;
        if (a == 'h7ff) wip = d & 'h7f;
        if (a < 'h7fc || (a == 'h7ff && flg == 0)) begin
            pa.push_back(a);
            pd.push_back(a == 'h7ff ? (d & 'h7f) : d);
        end
    endtask : wr
    // Busy must rise right after the stop only when non-volatile bytes are pending
    task automatic stp();
        int n;
        n = 0;
        i_host.stop();
        #1;
        `CHK(busy, pa.size() != 0)
        while (busy === 1'b1 && n < 1000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK(n <= PROG_C + 2, 1'b1)
        foreach (pa[i]) nv[pa[i]] = pd[i];
        pa.delete();
        pd.delete();
    endtask : stp
    task automatic rd(input int a);
        i_host.read(ADDR_W'(a));
        #1;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, DATA_W'(exp_rd(a)))
    endtask : rd
    initial begin
        void'($urandom(32'h14a9));
        repeat (5) @(posedge mclk);
        #1;
        chk_wiper();
        `CHK(volatile_only_flag, 1'b0)
        @(posedge mclk) resetn <= 1'b1;
        i_host.ready();
        wr('h7ff, 'h00);
        stp();
        chk_wiper();
        rd('h7ff);
        wr('h7ff, 'hff);
        stp();
        chk_wiper();
        rd('h7ff);
        for (int k = 0; k < 4; k++) begin
            p = (k == 0) ? 0 : (k == 3) ? 127 : $urandom_range(1, 126);
            for (int i = 0; i < 16; i++) wr(p * 16 + i, $urandom_range(0, 255));
            stp();
            chk_wiper();
            for (int i = 0; i < 16; i++) if (p * 16 + i < 'h7fc || p * 16 + i > 'h7fd) rd(p * 16 + i);
        end
        wr('h7fe, 'hff);
        stp();
        `CHK(volatile_only_flag, 1'b1)
        rd('h7fe);
        for (int i = 0; i < 10; i++) begin
            c = (i < 2) ? i * 127 : $urandom_range(0, 127);
            wr('h7ff, c);
            stp();
            chk_wiper();
            rd('h7ff);
        end
        wr('h7fe, 'h00);
        stp();
        rd('h7ff);
        @(posedge mclk) resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        wip = 'h40;
        flg = 0;
        #1;
        chk_wiper();
        `CHK(volatile_only_flag, 1'b0)
        @(posedge mclk) resetn <= 1'b1;
        i_host.ready();
        wip = nv['h7ff];
        chk_wiper();
        rd('h7ff);
        end_of_test();
    end
endmodule : testbench
